/* File: ascr_top.sv */
// converter control: sleep handling, reset effects, register file on APB
//
// Notes on behaviour
// - RC clock, sleep without converter irq: power down after conversion, enable stays set.
// - non-RC clock: sleep aborts conversion and powers down, enable stays set.
// - converter runs during sleep only with the RC clock select encoding.
// - any reset restores converter registers, powers down, aborts conversion.
// - reset never alters the result pair.
// - software clearing go/done aborts, keeps old result, waits two bit periods.
// - clock select picks 2, 8, 32 oscillator periods or RC oscillator.
// - with every clock select, RC included, start is delayed one instruction cycle after go/done.
// - completion clears go/done, loads result, sets flag, wakes if irq enabled.
`timescale 1ns/1ps
module ascr_top #(
	parameter int unsigned ADDR_WIDTH = 12
) (
	input wire logic MCLK,
	input wire logic RESET_N,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [ADDR_WIDTH-1:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic SLEEP,
	input wire logic RC_TICK,
	input wire logic [9:0] ANALOG_CODE,
	output logic CONV_POWERED,
	output logic HOLD_DISCONNECT,
	output logic [2:0] CHANNEL,
	output logic [3:0] PIN_CONFIG,
	output logic WAKE_REQ,
	output logic CPU_IRQ,
	output logic IRQ
);
	if (ADDR_WIDTH < 10 || ADDR_WIDTH > 32) begin : g_check
		$error("ascr_top: ADDR_WIDTH must lie between 10 and 32");
	end

	ascr_pkg::ascr_ctl0_t ctl0_q;
	ascr_pkg::ascr_ctl1_t ctl1_q;
	logic [7:0] interrupt_control_q;
	logic [7:0] flags_q;
	logic [7:0] enables_q;
	logic [7:0] res_high_q;
	logic [7:0] res_low_q;
	logic [ascr_pkg::ASCR_EV_COUNT-1:0] irq_status_q;
	logic [ascr_pkg::ASCR_EV_COUNT-1:0] irq_mask_q;
	logic [31:0] prdata_q;
	logic wake_q;
	logic sleep_q;
	ascr_pkg::ascr_state_t state_q;
	logic [3:0] bit_cnt_q;
	logic [2:0] delay_cnt_q;
	logic [1:0] hold_cnt_q;
	logic [9:0] code_q;
	logic [9:0] sar_q;

	logic setup;
	logic access;
	logic wr;
	logic rd;
	logic mapped;
	logic [7:0] rd_byte;
	logic tad_tick;
	logic tad_run;
	logic is_rc;
	logic sleep_enter;
	logic converting;
	logic done;
	logic sleep_abort;
	logic sw_abort;
	logic wr_ctl0;
	logic [ascr_pkg::ASCR_EV_COUNT-1:0] events;
	logic [9:0] sar_next;
	ascr_pkg::ascr_ctl0_t wr_ctl0_val;
	ascr_pkg::ascr_result_t justified;

	// true when the word address on the bus selects the register index
	function automatic logic hit(input logic [ADDR_WIDTH-1:0] addr, input logic [7:0] idx);
		hit = (addr[ADDR_WIDTH-1:2] == (ADDR_WIDTH-2)'(idx));
	endfunction

	assign setup = PSEL && !PENABLE;
	assign access = PSEL && PENABLE;
	assign wr = access && PWRITE && mapped;
	assign rd = access && !PWRITE && mapped;
	assign PREADY = 1'b1;
	assign PSLVERR = access && !mapped;
	assign PRDATA = prdata_q;

	always_comb begin
		mapped = 1'b1;
		rd_byte = 8'h00;
		if (hit(PADDR, ascr_pkg::ASCR_IDX_INTERRUPT_CONTROL)) begin
			rd_byte = interrupt_control_q;
		end else if (hit(PADDR, ascr_pkg::ASCR_IDX_PERIPHERAL_IRQ_FLAGS)) begin
			rd_byte = flags_q & ascr_pkg::ASCR_PERIPHERAL_IMPL_MASK;
		end else if (hit(PADDR, ascr_pkg::ASCR_IDX_PERIPHERAL_IRQ_ENABLES)) begin
			rd_byte = enables_q & ascr_pkg::ASCR_PERIPHERAL_IMPL_MASK;
		end else if (hit(PADDR, ascr_pkg::ASCR_IDX_CONVERSION_RESULT_HIGH)) begin
			rd_byte = res_high_q;
		end else if (hit(PADDR, ascr_pkg::ASCR_IDX_CONVERSION_RESULT_LOW)) begin
			rd_byte = res_low_q;
		end else if (hit(PADDR, ascr_pkg::ASCR_IDX_CONVERTER_CONTROL_PRIMARY)) begin
			rd_byte = ctl0_q & ascr_pkg::ASCR_CONTROL_PRIMARY_IMPL_MASK;
		end else if (hit(PADDR, ascr_pkg::ASCR_IDX_CONVERTER_CONTROL_SECONDARY)) begin
			rd_byte = ctl1_q & ascr_pkg::ASCR_CONTROL_SECONDARY_IMPL_MASK;
		end else if (hit(PADDR, ascr_pkg::ASCR_IDX_IRQ_STATUS)) begin
			rd_byte = 8'(irq_status_q);
		end else if (hit(PADDR, ascr_pkg::ASCR_IDX_IRQ_MASK)) begin
			rd_byte = 8'(irq_mask_q);
		end else begin
			mapped = 1'b0;
		end
	end

	// read data is captured in the setup cycle so it comes from a flip-flop in the access cycle
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			prdata_q <= 32'h0000_0000;
		end else if (setup) begin
			prdata_q <= {24'h00_0000, rd_byte};
		end
	end

	assign is_rc = (ctl0_q.conversion_clock_select == ascr_pkg::ASCR_CLK_RC);
	assign sleep_enter = SLEEP && !sleep_q;
	assign converting = (state_q == ascr_pkg::ASCR_ST_DELAY) || (state_q == ascr_pkg::ASCR_ST_CONV);
	assign wr_ctl0 = wr && hit(PADDR, ascr_pkg::ASCR_IDX_CONVERTER_CONTROL_PRIMARY);
	assign wr_ctl0_val = ascr_pkg::ascr_ctl0_t'(PWDATA[7:0] & ascr_pkg::ASCR_CONTROL_PRIMARY_IMPL_MASK);
	assign done = (state_q == ascr_pkg::ASCR_ST_CONV) && tad_tick
		&& (bit_cnt_q == 4'(ascr_pkg::ASCR_CONV_TAD - 1)) && ctl0_q.go_done;
	// only the RC clock keeps converting across sleep entry
	assign sleep_abort = converting && sleep_enter && !is_rc;
	assign sw_abort = converting && !ctl0_q.go_done && !sleep_abort;
	// an abort restarts the divider so the holdoff lasts two whole bit periods
	assign tad_run = ((state_q == ascr_pkg::ASCR_ST_CONV) && !sw_abort)
		|| (state_q == ascr_pkg::ASCR_ST_HOLD);

	ascr_tad_gen u_tad (
		.clk(MCLK),
		.rst_n(RESET_N),
		.run(tad_run),
		.sel(ctl0_q.conversion_clock_select),
		.rc_tick(RC_TICK),
		.tick(tad_tick)
	);

	// one result bit resolves per bit period, msb first
	always_comb begin
		sar_next = sar_q;
		if (bit_cnt_q >= 4'h1) begin
			sar_next[4'd10 - bit_cnt_q] = code_q[4'd10 - bit_cnt_q];
		end
	end

	ascr_justify u_justify (
		.result(sar_next),
		.right_justify(ctl1_q.result_justify_select),
		.packed_result(justified)
	);

	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			sleep_q <= 1'b0;
		end else begin
			sleep_q <= SLEEP;
		end
	end

	// conversion sequencer
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			state_q <= ascr_pkg::ASCR_ST_IDLE;
			bit_cnt_q <= 4'h0;
			delay_cnt_q <= 3'h0;
			hold_cnt_q <= 2'h0;
			code_q <= 10'h000;
			sar_q <= 10'h000;
		end else if (!ctl0_q.converter_power_on) begin
			state_q <= ascr_pkg::ASCR_ST_IDLE;
		end else begin
			unique case (state_q)
				ascr_pkg::ASCR_ST_IDLE: begin
					if (SLEEP && (!is_rc || (!ctl0_q.go_done
						&& !enables_q[ascr_pkg::ASCR_CONVERSION_DONE_POS]))) begin
						state_q <= ascr_pkg::ASCR_ST_DOWN;
					end else if (ctl0_q.go_done) begin
						state_q <= ascr_pkg::ASCR_ST_DELAY;
						delay_cnt_q <= 3'h0;
					end
				end
				ascr_pkg::ASCR_ST_DELAY: begin
					if (sleep_abort) begin
						state_q <= ascr_pkg::ASCR_ST_DOWN;
					end else if (sw_abort) begin
						state_q <= ascr_pkg::ASCR_ST_HOLD;
						hold_cnt_q <= 2'h0;
					end else if (delay_cnt_q == 3'(ascr_pkg::ASCR_INSTR_CYCLE_TOSC - 1)) begin
						state_q <= ascr_pkg::ASCR_ST_CONV;
						bit_cnt_q <= 4'h0;
						code_q <= ANALOG_CODE;
						sar_q <= 10'h000;
					end else begin
						delay_cnt_q <= delay_cnt_q + 3'h1;
					end
				end
				ascr_pkg::ASCR_ST_CONV: begin
					if (sleep_abort) begin
						state_q <= ascr_pkg::ASCR_ST_DOWN;
					end else if (sw_abort) begin
						state_q <= ascr_pkg::ASCR_ST_HOLD;
						hold_cnt_q <= 2'h0;
					end else if (done) begin
						hold_cnt_q <= 2'h0;
						if (SLEEP && !enables_q[ascr_pkg::ASCR_CONVERSION_DONE_POS]) begin
							state_q <= ascr_pkg::ASCR_ST_DOWN;
						end else begin
							state_q <= ascr_pkg::ASCR_ST_HOLD;
						end
					end else if (tad_tick) begin
						bit_cnt_q <= bit_cnt_q + 4'h1;
						sar_q <= sar_next;
					end
				end
				ascr_pkg::ASCR_ST_HOLD: begin
					// holding capacitor stays disconnected for two bit periods
					if (tad_tick) begin
						if (hold_cnt_q == 2'(ascr_pkg::ASCR_HOLDOFF_TAD - 1)) begin
							state_q <= ascr_pkg::ASCR_ST_IDLE;
						end else begin
							hold_cnt_q <= hold_cnt_q + 2'h1;
						end
					end
				end
				ascr_pkg::ASCR_ST_DOWN: begin
					if (!SLEEP || (wr_ctl0 && wr_ctl0_val.converter_power_on)) begin
						state_q <= ascr_pkg::ASCR_ST_IDLE;
					end
				end
				default: begin
					state_q <= ascr_pkg::ASCR_ST_IDLE;
				end
			endcase
		end
	end

	// primary control; a software write outranks the hardware clear of go/done
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			ctl0_q <= ascr_pkg::ascr_ctl0_t'(ascr_pkg::ASCR_CONTROL_PRIMARY_RST);
		end else if (wr_ctl0) begin
			ctl0_q <= wr_ctl0_val;
		end else if (done || sleep_abort) begin
			ctl0_q.go_done <= 1'b0;
		end else if (state_q == ascr_pkg::ASCR_ST_DOWN) begin
			ctl0_q.go_done <= 1'b0;
		end
	end

	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			ctl1_q <= ascr_pkg::ascr_ctl1_t'(ascr_pkg::ASCR_CONTROL_SECONDARY_RST);
		end else if (wr && hit(PADDR, ascr_pkg::ASCR_IDX_CONVERTER_CONTROL_SECONDARY)) begin
			ctl1_q <= ascr_pkg::ascr_ctl1_t'(PWDATA[7:0] & ascr_pkg::ASCR_CONTROL_SECONDARY_IMPL_MASK);
		end
	end

	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			interrupt_control_q <= ascr_pkg::ASCR_INTERRUPT_CONTROL_RST;
		end else if (wr && hit(PADDR, ascr_pkg::ASCR_IDX_INTERRUPT_CONTROL)) begin
			interrupt_control_q <= PWDATA[7:0];
		end
	end

	// reserved positions are not stored, so they always read back as zero
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			enables_q <= ascr_pkg::ASCR_PERIPHERAL_IRQ_ENABLES_RST;
		end else if (wr && hit(PADDR, ascr_pkg::ASCR_IDX_PERIPHERAL_IRQ_ENABLES)) begin
			enables_q <= PWDATA[7:0] & ascr_pkg::ASCR_PERIPHERAL_IMPL_MASK;
		end
	end

	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			flags_q <= ascr_pkg::ASCR_PERIPHERAL_IRQ_FLAGS_RST;
		end else begin
			if (wr && hit(PADDR, ascr_pkg::ASCR_IDX_PERIPHERAL_IRQ_FLAGS)) begin
				flags_q <= PWDATA[7:0] & ascr_pkg::ASCR_PERIPHERAL_IMPL_MASK;
			end
			if (done) begin
				flags_q[ascr_pkg::ASCR_CONVERSION_DONE_POS] <= 1'b1;
			end
		end
	end

	// result pair has no reset so any reset leaves its contents alone
	always_ff @(posedge MCLK) begin
		if (RESET_N) begin
			if (done) begin
				res_high_q <= justified.high;
				res_low_q <= justified.low;
			end else begin
				if (wr && hit(PADDR, ascr_pkg::ASCR_IDX_CONVERSION_RESULT_HIGH)) begin
					res_high_q <= PWDATA[7:0];
				end
				if (wr && hit(PADDR, ascr_pkg::ASCR_IDX_CONVERSION_RESULT_LOW)) begin
					res_low_q <= PWDATA[7:0];
				end
			end
		end
	end

	// wake only from sleep and only with the converter interrupt enabled
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			wake_q <= 1'b0;
		end else begin
			wake_q <= done && SLEEP && enables_q[ascr_pkg::ASCR_CONVERSION_DONE_POS];
		end
	end

	always_comb begin
		events = '0;
		events[ascr_pkg::ASCR_EV_DONE_POS] = done;
		events[ascr_pkg::ASCR_EV_SLEEP_ABORT_POS] = sleep_abort;
		events[ascr_pkg::ASCR_EV_SW_ABORT_POS] = sw_abort;
	end

	// read clears, but an event in the same cycle survives the clear
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			irq_status_q <= ascr_pkg::ASCR_IRQ_REG_RST[ascr_pkg::ASCR_EV_COUNT-1:0];
		end else if (rd && hit(PADDR, ascr_pkg::ASCR_IDX_IRQ_STATUS)) begin
			irq_status_q <= events;
		end else begin
			irq_status_q <= irq_status_q | events;
		end
	end

	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			irq_mask_q <= ascr_pkg::ASCR_IRQ_REG_RST[ascr_pkg::ASCR_EV_COUNT-1:0];
		end else if (wr && hit(PADDR, ascr_pkg::ASCR_IDX_IRQ_MASK)) begin
			irq_mask_q <= PWDATA[ascr_pkg::ASCR_EV_COUNT-1:0];
		end
	end

	assign IRQ = |(irq_status_q & irq_mask_q);
	assign CPU_IRQ = interrupt_control_q[ascr_pkg::ASCR_GLOBAL_IRQ_ENABLE_POS]
		&& interrupt_control_q[ascr_pkg::ASCR_PERIPHERAL_IRQ_ENABLE_POS]
		&& flags_q[ascr_pkg::ASCR_CONVERSION_DONE_POS]
		&& enables_q[ascr_pkg::ASCR_CONVERSION_DONE_POS];
	assign WAKE_REQ = wake_q;
	// powered off by sleep while the enable bit still reads set
	assign CONV_POWERED = ctl0_q.converter_power_on && (state_q != ascr_pkg::ASCR_ST_DOWN);
	assign HOLD_DISCONNECT = (state_q == ascr_pkg::ASCR_ST_CONV) || (state_q == ascr_pkg::ASCR_ST_HOLD);
	assign CHANNEL = ctl0_q.input_channel_select;
	assign PIN_CONFIG = ctl1_q.pin_analog_config;
endmodule // ascr_top

/* File: ascr_pkg.sv */
// shared constants, register map and types of the converter sleep/reset control block
package ascr_pkg;
	// register indices; byte address on the bus is four times the index
	localparam logic [7:0] ASCR_IDX_INTERRUPT_CONTROL = 8'h0b;
	localparam logic [7:0] ASCR_IDX_PERIPHERAL_IRQ_FLAGS = 8'h0c;
	localparam logic [7:0] ASCR_IDX_CONVERSION_RESULT_HIGH = 8'h1e;
	localparam logic [7:0] ASCR_IDX_CONVERTER_CONTROL_PRIMARY = 8'h1f;
	localparam logic [7:0] ASCR_IDX_PERIPHERAL_IRQ_ENABLES = 8'h8c;
	localparam logic [7:0] ASCR_IDX_CONVERSION_RESULT_LOW = 8'h9e;
	localparam logic [7:0] ASCR_IDX_CONVERTER_CONTROL_SECONDARY = 8'h9f;
	localparam logic [7:0] ASCR_IDX_IRQ_STATUS = 8'ha0;
	localparam logic [7:0] ASCR_IDX_IRQ_MASK = 8'ha1;

	// field positions
	localparam int unsigned ASCR_GLOBAL_IRQ_ENABLE_POS = 7;
	localparam int unsigned ASCR_PERIPHERAL_IRQ_ENABLE_POS = 6;
	localparam int unsigned ASCR_CONVERSION_DONE_POS = 6;
	localparam int unsigned ASCR_EV_DONE_POS = 0;
	localparam int unsigned ASCR_EV_SLEEP_ABORT_POS = 1;
	localparam int unsigned ASCR_EV_SW_ABORT_POS = 2;
	localparam int unsigned ASCR_EV_COUNT = 3;

	// reset values and implemented-bit masks
	localparam logic [7:0] ASCR_INTERRUPT_CONTROL_RST = 8'h00;
	localparam logic [7:0] ASCR_PERIPHERAL_IRQ_FLAGS_RST = 8'h00;
	localparam logic [7:0] ASCR_PERIPHERAL_IRQ_ENABLES_RST = 8'h00;
	localparam logic [7:0] ASCR_CONTROL_PRIMARY_RST = 8'h00;
	localparam logic [7:0] ASCR_CONTROL_SECONDARY_RST = 8'h00;
	localparam logic [7:0] ASCR_IRQ_REG_RST = 8'h00;
	localparam logic [7:0] ASCR_PERIPHERAL_IMPL_MASK = 8'h4f;
	localparam logic [7:0] ASCR_CONTROL_PRIMARY_IMPL_MASK = 8'hfd;
	localparam logic [7:0] ASCR_CONTROL_SECONDARY_IMPL_MASK = 8'h8f;

	// timing, in oscillator periods (one MCLK period) or in bit periods
	localparam int unsigned ASCR_DIV2_TOSC = 2;
	localparam int unsigned ASCR_DIV8_TOSC = 8;
	localparam int unsigned ASCR_DIV32_TOSC = 32;
	localparam int unsigned ASCR_INSTR_CYCLE_TOSC = 4;
	localparam int unsigned ASCR_HOLDOFF_TAD = 2;
	localparam int unsigned ASCR_CONV_TAD = 11;
	localparam int unsigned ASCR_RESULT_BITS = 10;

	typedef enum logic [1:0] {
		ASCR_CLK_DIV2 = 2'b00,
		ASCR_CLK_DIV8 = 2'b01,
		ASCR_CLK_DIV32 = 2'b10,
		ASCR_CLK_RC = 2'b11
	} ascr_clk_sel_t;

	typedef enum logic [2:0] {
		ASCR_ST_IDLE = 3'b000,
		ASCR_ST_DELAY = 3'b001,
		ASCR_ST_CONV = 3'b010,
		ASCR_ST_HOLD = 3'b011,
		ASCR_ST_DOWN = 3'b100
	} ascr_state_t;

	typedef struct packed {
		ascr_clk_sel_t conversion_clock_select;
		logic [2:0] input_channel_select;
		logic go_done;
		logic unused;
		logic converter_power_on;
	} ascr_ctl0_t;

	typedef struct packed {
		logic result_justify_select;
		logic [2:0] unused;
		logic [3:0] pin_analog_config;
	} ascr_ctl1_t;

	typedef struct packed {
		logic [7:0] high;
		logic [7:0] low;
	} ascr_result_t;
endpackage

/* File: ascr_tad_gen.sv */
// bit-period tick generator for the converter
`timescale 1ns/1ps
module ascr_tad_gen (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic run,
	input wire ascr_pkg::ascr_clk_sel_t sel,
	input wire logic rc_tick,
	output logic tick
);
	logic [4:0] div_q;
	logic [4:0] last;

	always_comb begin
		unique case (sel)
			ascr_pkg::ASCR_CLK_DIV2: last = 5'(ascr_pkg::ASCR_DIV2_TOSC - 1);
			ascr_pkg::ASCR_CLK_DIV8: last = 5'(ascr_pkg::ASCR_DIV8_TOSC - 1);
			ascr_pkg::ASCR_CLK_DIV32: last = 5'(ascr_pkg::ASCR_DIV32_TOSC - 1);
			ascr_pkg::ASCR_CLK_RC: last = 5'h00;
		endcase
	end

	// divider restarts whenever the converter stops so the first period is whole
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			div_q <= 5'h00;
		end else if (!run || div_q == last) begin
			div_q <= 5'h00;
		end else begin
			div_q <= div_q + 5'h01;
		end
	end

	assign tick = run && ((sel == ascr_pkg::ASCR_CLK_RC) ? rc_tick : (div_q == last));
endmodule // ascr_tad_gen

/* File: ascr_justify.sv */
// places the 10-bit result into the 16-bit result pair
`timescale 1ns/1ps
module ascr_justify (
	input wire logic [9:0] result,
	input wire logic right_justify,
	output ascr_pkg::ascr_result_t packed_result
);
	assign packed_result = right_justify ? {6'h00, result} : {result, 6'h00};
endmodule // ascr_justify

/* File: ascr_assertions.sv */
// concurrent checks on the ports of the converter sleep/reset control block
`timescale 1ns/1ps
module ascr_assertions #(
	parameter int unsigned ADDR_WIDTH = 12
) (
	input wire logic MCLK,
	input wire logic RESET_N,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [ADDR_WIDTH-1:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [31:0] PRDATA,
	input wire logic PREADY,
	input wire logic PSLVERR,
	input wire logic SLEEP,
	input wire logic CONV_POWERED,
	input wire logic HOLD_DISCONNECT,
	input wire logic WAKE_REQ,
	input wire logic CPU_IRQ,
	input wire logic IRQ
);
	logic [11:0] a12;
	logic wr;
	logic mapped;
	logic [7:0] ctl_q, en_q, ic_q;
	assign a12 = 12'(PADDR);
	assign wr = PSEL && PENABLE && PWRITE && PREADY;
	assign mapped = a12 inside {12'h02c, 12'h030, 12'h078, 12'h07c, 12'h230, 12'h278, 12'h27c,
		12'h280, 12'h284};
	// shadows of software-owned bits; hardware only clears go/done, which is not used here
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			ctl_q <= 8'h00;
			en_q <= 8'h00;
			ic_q <= 8'h00;
		end else if (wr) begin
			if (a12 == 12'h07c) ctl_q <= PWDATA[7:0];
			if (a12 == 12'h230) en_q <= PWDATA[7:0];
			if (a12 == 12'h02c) ic_q <= PWDATA[7:0];
		end
	end
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RESET_N);
	property p_nonrc_sleep_down;
		(SLEEP && ctl_q[7:6] != 2'b11 && !wr) [*4] |-> !CONV_POWERED;
	endproperty
	a_nonrc_sleep_down: assert property (p_nonrc_sleep_down) else $error("awake in sleep");
	property p_rc_sleep_runs;
		SLEEP && ctl_q[7:6] == 2'b11 && en_q[6] && ctl_q[0] && $past(CONV_POWERED) |-> CONV_POWERED;
	endproperty
	a_rc_sleep_runs: assert property (p_rc_sleep_runs) else $error("rc sleep power loss");
	property p_wake_enabled;
		WAKE_REQ |-> en_q[6] && $past(SLEEP);
	endproperty
	a_wake_enabled: assert property (p_wake_enabled) else $error("wake without enable");
	property p_wake_pulse;
		WAKE_REQ |=> !WAKE_REQ;
	endproperty
	a_wake_pulse: assert property (p_wake_pulse) else $error("wake longer than a cycle");
	property p_cpu_irq;
		CPU_IRQ |-> ic_q[7] && ic_q[6] && en_q[6];
	endproperty
	a_cpu_irq: assert property (p_cpu_irq) else $error("cpu irq not gated");
	property p_bus_map;
		PSEL && PENABLE |-> PREADY && PSLVERR == !mapped && PRDATA[31:8] == 24'h000000;
	endproperty
	a_bus_map: assert property (p_bus_map) else $error("bad bus answer");
	property p_go_start;
		wr && a12 == 12'h07c && PWDATA[2] && PWDATA[0] && ctl_q[0] && !HOLD_DISCONNECT
			|=> !HOLD_DISCONNECT [*3] ##[1:40] HOLD_DISCONNECT;
	endproperty
	a_go_start: assert property (p_go_start) else $error("conversion start timing");
	property p_reset_outs;
		$rose(RESET_N) |-> !IRQ && !CPU_IRQ && !CONV_POWERED && !HOLD_DISCONNECT && !WAKE_REQ;
	endproperty
	a_reset_outs: assert property (p_reset_outs) else $error("outputs after reset");
	c_wake: cover property (WAKE_REQ);
	c_sleep_down: cover property ($fell(CONV_POWERED) && SLEEP);
	c_unmapped: cover property (PSEL && PENABLE && PSLVERR);
endmodule // ascr_assertions

bind ascr_top ascr_assertions #(.ADDR_WIDTH(ADDR_WIDTH)) u_ascr_chk (.MCLK(MCLK),
	.RESET_N(RESET_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
	.PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .SLEEP(SLEEP),
	.CONV_POWERED(CONV_POWERED), .HOLD_DISCONNECT(HOLD_DISCONNECT), .WAKE_REQ(WAKE_REQ),
	.CPU_IRQ(CPU_IRQ), .IRQ(IRQ));

/* File: ascr_top_tb.sv */
// self-checking testbench of the converter sleep/reset control block
`timescale 1ns/1ps
module ascr_top_tb;
	localparam logic [7:0] R_IC = 8'h0b, R_FL = 8'h0c, R_RH = 8'h1e, R_C0 = 8'h1f, R_EN = 8'h8c;
	localparam logic [7:0] R_RL = 8'h9e, R_C1 = 8'h9f, R_ST = 8'ha0, R_MK = 8'ha1;
	logic mclk = 1'b0;
	logic reset_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic sleep = 1'b0;
	logic rc_tick = 1'b0;
	logic [9:0] analog_code = 10'h000;
	logic [31:0] prdata;
	logic pready, pslverr, conv_powered, hold_disconnect, wake_req, cpu_irq, irq;
	logic [2:0] channel;
	logic [3:0] pin_config;
	logic [3:0] rc_div = 4'h0;
	logic [7:0] q, rh, rl;
	logic e;
	int error_cnt = 0;
	int cmp_count = 0;
	int cyc = 0;
	int wake_cnt = 0;

	always #4 mclk = ~mclk;

	ascr_top #(.ADDR_WIDTH(12)) DUT (.MCLK(mclk), .RESET_N(reset_n), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
		.PREADY(pready), .PSLVERR(pslverr), .SLEEP(sleep), .RC_TICK(rc_tick),
		.ANALOG_CODE(analog_code), .CONV_POWERED(conv_powered), .HOLD_DISCONNECT(hold_disconnect),
		.CHANNEL(channel), .PIN_CONFIG(pin_config), .WAKE_REQ(wake_req), .CPU_IRQ(cpu_irq),
		.IRQ(irq));

	// stand-in for the internal rc oscillator: one tick every 16 clocks, free running
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		rc_div <= rc_div + 4'h1;
		rc_tick <= (rc_div == 4'hf);
		if (wake_req === 1'b1) wake_cnt <= wake_cnt + 1;
		if (cyc == 20000) begin
			error_cnt = error_cnt + 1;
			$display("ERROR cycle_limit expected below %0d seen %0d", 20000, cyc);
			close_out();
		end
	end

	task automatic close_out();
		if (error_cnt == 0 && cmp_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	task automatic chk8(input string n, input logic [7:0] x, input logic [7:0] g);
		cmp_count++;
		if (g !== x) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", n, x, g);
		end
	endtask

	task automatic chk1(input string n, input logic x, input logic g);
		cmp_count++;
		if (g !== x) begin
			error_cnt++;
			$display("ERROR %s expected %b seen %b", n, x, g);
		end
	endtask

	task automatic acc(input logic w, input logic [7:0] i, input logic [7:0] d);
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {2'b00, i, 2'b00};
		pwdata <= {24'h000000, d};
		@(posedge mclk);
		penable <= 1'b1;
		// no wait-state limit here: a hang ends at the bench cycle ceiling
		do begin
			@(posedge mclk);
		end while (pready !== 1'b1);
		q = prdata[7:0];
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rdc(input logic [7:0] i, input logic [7:0] x);
		acc(1'b0, i, 8'h00);
		chk8("reg_read", x, q);
	endtask

	task automatic wirq(output int n);
		n = 0;
		while (irq !== 1'b1 && n < 2000) begin
			@(posedge mclk);
			n++;
		end
	endtask

	task automatic whold(output int n);
		n = 0;
		while (hold_disconnect !== 1'b0 && n < 1000) begin
			@(posedge mclk);
			n++;
		end
	endtask

	task automatic conv(input logic [1:0] s, input logic j, input logic [9:0] c);
		int n;
		int d;
		d = (s == 2'b00) ? 2 : (s == 2'b01) ? 8 : 32;
		whold(n);
		analog_code <= c;
		acc(1'b1, R_C1, {j, 7'h00});
		acc(1'b0, R_ST, 8'h00);
		acc(1'b1, R_C0, {s, 6'b010101});
		wirq(n);
		chk1("done_time", 1'b1, n >= 10 * d && n <= 12 * d + 10);
		chk1("cpu_irq", 1'b1, cpu_irq);
		{rh, rl} = j ? {6'h00, c} : {c, 6'h00};
		rdc(R_RH, rh);
		rdc(R_RL, rl);
		rdc(R_C0, {s, 6'b010001});
		rdc(R_FL, 8'h40);
		rdc(R_ST, 8'h01);
		rdc(R_ST, 8'h00);
		acc(1'b1, R_FL, 8'h00);
		@(posedge mclk);
		chk1("cpu_irq_clr", 1'b0, cpu_irq);
	endtask

	task automatic sw_abort();
		int n;
		whold(n);
		acc(1'b1, R_C0, 8'had);
		repeat (40) @(posedge mclk);
		acc(1'b1, R_C0, 8'ha9);
		whold(n);
		chk1("holdoff", 1'b1, n >= 64 && n <= 72);
		chk1("irq_masked", 1'b0, irq);
		rdc(R_ST, 8'h04);
		rdc(R_RH, rh);
		rdc(R_RL, rl);
		rdc(R_C0, 8'ha9);
	endtask

	task automatic sleep_abort();
		acc(1'b1, R_MK, 8'h03);
		acc(1'b1, R_C0, 8'h6d);
		repeat (30) @(posedge mclk);
		sleep <= 1'b1;
		repeat (4) @(posedge mclk);
		chk1("sleep_down", 1'b0, conv_powered);
		chk1("irq_sleep", 1'b1, irq);
		rdc(R_C0, 8'h69);
		rdc(R_ST, 8'h02);
		@(posedge mclk);
		chk1("irq_clr", 1'b0, irq);
		rdc(R_RH, rh);
		sleep <= 1'b0;
		repeat (2) @(posedge mclk);
		chk1("sleep_up", 1'b1, conv_powered);
	endtask

	task automatic rc_sleep(input logic ie, input logic [9:0] c);
		int n;
		int w;
		w = wake_cnt;
		analog_code <= c;
		acc(1'b1, R_EN, {1'b0, ie, 6'h00});
		acc(1'b1, R_C1, 8'h80);
		acc(1'b1, R_C0, 8'hed);
		sleep <= 1'b1;
		wirq(n);
		repeat (3) @(posedge mclk);
		chk1("rc_wake", ie, wake_cnt != w);
		chk1("rc_power", ie, conv_powered);
		{rh, rl} = {6'h00, c};
		rdc(R_RH, rh);
		rdc(R_RL, rl);
		rdc(R_C0, 8'he9);
		rdc(R_ST, 8'h01);
		acc(1'b1, R_FL, 8'h00);
		sleep <= 1'b0;
		repeat (2) @(posedge mclk);
		chk1("rc_up", 1'b1, conv_powered);
	endtask

	task automatic mid_reset();
		acc(1'b1, R_IC, 8'hc0);
		acc(1'b1, R_C1, 8'h8f);
		acc(1'b1, R_C0, 8'had);
		repeat (20) @(posedge mclk);
		chk8("channel", 8'h05, {5'h00, channel});
		chk8("pin_config", 8'h0f, {4'h0, pin_config});
		reset_n <= 1'b0;
		repeat (3) @(posedge mclk);
		chk1("rst_power", 1'b0, conv_powered);
		reset_n <= 1'b1;
		@(posedge mclk);
		chk1("rst_hold", 1'b0, hold_disconnect);
		chk8("rst_channel", 8'h00, {5'h00, channel});
		chk8("rst_pin_config", 8'h00, {4'h0, pin_config});
		rdc(R_C0, 8'h00);
		rdc(R_C1, 8'h00);
		rdc(R_IC, 8'h00);
		rdc(R_EN, 8'h00);
		rdc(R_MK, 8'h00);
		rdc(R_RH, rh);
		rdc(R_RL, rl);
	endtask

	initial begin
		repeat (5) @(posedge mclk);
		reset_n <= 1'b1;
		rdc(R_C0, 8'h00);
		rdc(R_FL, 8'h00);
		acc(1'b1, 8'h40, 8'h5a);
		chk1("unmapped_err", 1'b1, e);
		acc(1'b0, 8'h40, 8'h00);
		chk8("unmapped_rd", 8'h00, q);
		acc(1'b1, R_C1, 8'hff);
		rdc(R_C1, 8'h8f);
		acc(1'b1, R_C0, 8'h01);
		acc(1'b1, R_IC, 8'hc0);
		acc(1'b1, R_EN, 8'h40);
		acc(1'b1, R_MK, 8'h01);
		conv(2'b00, 1'b1, 10'h2b5);
		conv(2'b01, 1'b0, 10'h1c3);
		conv(2'b10, 1'b1, 10'h35a);
		sw_abort();
		sleep_abort();
		rc_sleep(1'b0, 10'h0f3);
		rc_sleep(1'b1, 10'h30c);
		mid_reset();
		close_out();
	end
endmodule // ascr_top_tb
